// ### src/jhvb_pkg.sv
// Notes on behaviour
// - Vector register shows pending source code times four, for jump tables.
// - Codes: 0 none, 1 EOF, 2 IN_FRAME_RESPONSE byte, 3 rx full, 4 tx empty, 5-8 errors/wakeup.
// - Highest pending source is shown; wakeup highest; next one shows after a clear.
// - Vector read clears reported source, except rx full, IN_FRAME_RESPONSE byte, tx empty.
// - Rx full and IN_FRAME_RESPONSE byte clear on vector read then data register read.
// - Tx empty clears on vector read then data write, or end-of-data set.
// - Data write gives next tx byte; data read gives last received byte.
// - Shifter reloads from tx shadow; tx empty set after first bit shifted.
// - Complete rx byte copied to shadow, sets rx full or IN_FRAME_RESPONSE byte; next byte overwrites.
// - No tx byte supplied without end-of-data set means underrun; transmitter aborted at non-byte boundary.
// - Halted transmission is reported by receiver as invalid symbol error.
// - Wait instruction with wait clock mode clear enters wait; bus not driven.
// - In wait, a received message wakes device; clocks keep running.
// - Stop entered on stop instruction, or wait instruction with wait clock mode.
// - In stop, bus passive-to-active edge wakes device and requests NMI.
// - Waking byte valid only if stop came via wait after end of frame.
// - Stop during reception: first edge wakes, interrupts, resumes after restabilise.
package jhvb_pkg;
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_CTRL = 6'h3c;
  localparam logic [5:0] IDX_STAT = 6'h3d;
  localparam logic [5:0] IDX_ISV = 6'h3e;
  localparam logic [5:0] IDX_DATA = 6'h3f;
  localparam int CTRL_WAIT_CLOCK_MODE = 0;
  localparam int CTRL_IRQ_ENABLE = 1;
  localparam int CTRL_EOD = 2;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_EOF = 4'h1;
  localparam logic [3:0] SRC_IFR = 4'h2;
  localparam logic [3:0] SRC_RXF = 4'h3;
  localparam logic [3:0] SRC_TXE = 4'h4;
  localparam logic [3:0] SRC_ARB = 4'h5;
  localparam logic [3:0] SRC_CRC = 4'h6;
  localparam logic [3:0] SRC_SYM = 4'h7;
  localparam logic [3:0] SRC_WAKE = 4'h8;
  localparam logic [8:1] FLAGS_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 200;
  localparam int RESTAB_NS = 1000;
  localparam int RESTAB_CYC = (RESTAB_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {JHVB_RUN, JHVB_WAIT, JHVB_STOP} jhvb_pwr_t;
endpackage

// ### src/jhvb_top.sv
`timescale 1ns/1ps
module jhvb_top
  import jhvb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_is_ifr,
  input wire logic rx_eof,
  input wire logic rx_busy,
  input wire logic arb_lost,
  input wire logic crc_err,
  input wire logic symbol_err,
  input wire logic tx_need,
  input wire logic tx_first_bit,
  input wire logic eod_done,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic bus_rx,
  output logic tx_load,
  output logic [7:0] tx_byte,
  output logic tx_abort,
  output logic end_of_data_request,
  output logic bus_drive_en,
  output logic clocks_run,
  output logic comm_ready,
  output logic wake_byte_ok,
  output logic irq,
  output logic nmi_req
);

  function automatic logic [3:0] vec_code(input logic [8:1] f);
    logic [3:0] c;
    c = SRC_NONE;
    for (int i = 1; i <= 8; i++) begin
      if (f[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  logic [8:1] fl_r;
  logic [8:1] fl_set;
  logic [8:1] fl_clr;
  logic [3:0] vcode;
  logic aw_hold_r;
  logic w_hold_r;
  logic [5:0] aw_idx_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic wr_go;
  logic ar_go;
  logic [5:0] ar_idx;
  logic rd_isv_r;
  logic wait_clock_mode_r;
  logic irq_enable_bit_r;
  logic arm_rx_r;
  logic [3:0] arm_code_r;
  logic arm_tx_r;
  logic [7:0] tx_shadow_r;
  logic tx_full_r;
  logic [7:0] rx_shadow_r;
  jhvb_pwr_t pst_r;
  logic via_wait_r;
  logic eof_seen_r;
  logic rx_mid_r;
  logic [7:0] restab_r;
  logic bus_s1_r;
  logic bus_s2_r;
  logic bus_s3_r;
  logic bus_rise;
  logic isv_rd_now;
  logic data_rd_now;
  logic data_wr_now;
  logic eod_wr_now;

  assign vcode = vec_code(fl_r);
  assign wr_go = aw_hold_r && w_hold_r && !bvalid;
  assign ar_go = ce && arvalid && arready;
  assign ar_idx = araddr[7:2];
  assign isv_rd_now = ar_go && ar_idx == IDX_ISV;
  assign data_rd_now = ar_go && ar_idx == IDX_DATA;
  assign data_wr_now = ce && wr_go && wlane_r && aw_idx_r == IDX_DATA;
  assign eod_wr_now = ce && wr_go && wlane_r && aw_idx_r == IDX_CTRL &&
                      wbyte_r[CTRL_EOD];
  assign bus_rise = bus_s2_r && !bus_s3_r;

  // Write channel: address and data are taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      awready <= 1'b1;
      aw_idx_r <= 6'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awready <= 1'b0;
        aw_idx_r <= awaddr[7:2];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_hold_r <= 1'b0;
      wready <= 1'b1;
      wbyte_r <= BYTE_RST;
      wlane_r <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wready <= 1'b0;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
      if (wr_go) begin
        w_hold_r <= 1'b0;
      end
      if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // Unmapped words answer SLVERR; a write to the vector is accepted and lost
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (aw_idx_r >= IDX_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      rd_isv_r <= 1'b0;
    end else if (ce) begin
      if (ar_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rd_isv_r <= ar_idx == IDX_ISV;
        rresp <= (ar_idx >= IDX_CTRL) ? RESP_OKAY : RESP_SLVERR;
        case (ar_idx)
          IDX_CTRL: rdata <= {29'h0, end_of_data_request, irq_enable_bit_r,
                              wait_clock_mode_r};
          IDX_STAT: rdata <= {24'h0, rx_mid_r, eof_seen_r, arm_tx_r,
                              arm_rx_r, tx_full_r, via_wait_r, 2'(pst_r)};
          IDX_ISV: rdata <= {24'h0, 2'b00, vcode, 2'b00};
          IDX_DATA: rdata <= {24'h0, rx_shadow_r};
          default: rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_clock_mode_r <= 1'b0;
      irq_enable_bit_r <= 1'b0;
    end else if (ce && wr_go && wlane_r && aw_idx_r == IDX_CTRL) begin
      wait_clock_mode_r <= wbyte_r[CTRL_WAIT_CLOCK_MODE];
      irq_enable_bit_r <= wbyte_r[CTRL_IRQ_ENABLE];
    end
  end

  // Software set wins over the frame-end clear so a late request is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      end_of_data_request <= 1'b0;
    end else if (ce) begin
      if (eod_wr_now) begin
        end_of_data_request <= 1'b1;
      end else if (eod_done) begin
        end_of_data_request <= 1'b0;
      end
    end
  end

  // Arming: data-register sources wait for the matching data access
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_rx_r <= 1'b0;
      arm_code_r <= SRC_NONE;
      arm_tx_r <= 1'b0;
    end else if (ce) begin
      if (isv_rd_now && (vcode == SRC_IFR || vcode == SRC_RXF)) begin
        arm_rx_r <= 1'b1;
        arm_code_r <= vcode;
      end else if (data_rd_now) begin
        arm_rx_r <= 1'b0;
      end
      if (isv_rd_now && vcode == SRC_TXE) begin
        arm_tx_r <= 1'b1;
      end else if (data_wr_now || eod_wr_now) begin
        arm_tx_r <= 1'b0;
      end
    end
  end

  always_comb begin
    fl_clr = 8'h00;
    if (isv_rd_now && vcode != SRC_NONE && vcode != SRC_IFR &&
        vcode != SRC_RXF && vcode != SRC_TXE) begin
      fl_clr[vcode] = 1'b1;
    end
    if (data_rd_now && arm_rx_r) begin
      fl_clr[arm_code_r] = 1'b1;
    end
    if ((data_wr_now && arm_tx_r) || eod_wr_now) begin
      fl_clr[SRC_TXE] = 1'b1;
    end
  end

  always_comb begin
    fl_set = 8'h00;
    fl_set[SRC_EOF] = rx_eof;
    fl_set[SRC_IFR] = rx_byte_valid && rx_is_ifr;
    fl_set[SRC_RXF] = rx_byte_valid && !rx_is_ifr;
    fl_set[SRC_TXE] = tx_first_bit;
    fl_set[SRC_ARB] = arb_lost;
    fl_set[SRC_CRC] = crc_err;
    fl_set[SRC_SYM] = symbol_err;
    fl_set[SRC_WAKE] = pst_r == JHVB_STOP && bus_rise;
  end

  // A set in the cycle of its clear wins, so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_r <= FLAGS_RST;
    end else if (ce) begin
      fl_r <= (fl_r & ~fl_clr) | fl_set;
    end
  end

  // Shadow is overwritten if software is late; no overrun flag exists
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_shadow_r <= BYTE_RST;
    end else if (ce && rx_byte_valid) begin
      rx_shadow_r <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_shadow_r <= BYTE_RST;
      tx_full_r <= 1'b0;
      tx_load <= 1'b0;
      tx_byte <= BYTE_RST;
      tx_abort <= 1'b0;
    end else if (ce) begin
      tx_load <= 1'b0;
      tx_abort <= 1'b0;
      if (tx_need && tx_full_r) begin
        tx_load <= 1'b1;
        tx_byte <= tx_shadow_r;
        tx_full_r <= 1'b0;
      end else if (tx_need && !end_of_data_request) begin
        tx_abort <= 1'b1;
      end
      if (data_wr_now) begin
        tx_shadow_r <= wbyte_r;
        tx_full_r <= 1'b1;
      end
    end
  end

  // Pin synchroniser; edge detect only looks at the second stage onward
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_s1_r <= 1'b0;
      bus_s2_r <= 1'b0;
      bus_s3_r <= 1'b0;
    end else if (ce) begin
      bus_s1_r <= bus_rx;
      bus_s2_r <= bus_s1_r;
      bus_s3_r <= bus_s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eof_seen_r <= 1'b0;
    end else if (ce) begin
      if (rx_eof) begin
        eof_seen_r <= 1'b1;
      end else if (rx_busy) begin
        eof_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pst_r <= JHVB_RUN;
      via_wait_r <= 1'b0;
      rx_mid_r <= 1'b0;
      wake_byte_ok <= 1'b0;
    end else if (ce) begin
      case (pst_r)
        JHVB_RUN: begin
          if (cpu_stop || (cpu_wait && wait_clock_mode_r)) begin
            pst_r <= JHVB_STOP;
            via_wait_r <= !cpu_stop;
            rx_mid_r <= rx_busy;
            wake_byte_ok <= !cpu_stop && eof_seen_r && !rx_busy;
          end else if (cpu_wait) begin
            pst_r <= JHVB_WAIT;
          end
        end
        JHVB_WAIT: begin
          if (rx_eof) begin
            pst_r <= JHVB_RUN;
          end
        end
        JHVB_STOP: begin
          if (bus_rise) begin
            pst_r <= JHVB_RUN;
          end
        end
        default: pst_r <= JHVB_RUN;
      endcase
    end
  end

  // Comms hold off until the clocks restabilise after a stop wake
  always_ff @(posedge clk) begin
    if (rst) begin
      restab_r <= 8'h00;
      comm_ready <= 1'b1;
    end else if (ce) begin
      if (pst_r == JHVB_STOP) begin
        restab_r <= 8'(RESTAB_CYC);
        comm_ready <= 1'b0;
      end else if (restab_r != 8'h00) begin
        restab_r <= restab_r - 8'h01;
        comm_ready <= restab_r == 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_drive_en <= 1'b0;
      clocks_run <= 1'b1;
      nmi_req <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      bus_drive_en <= pst_r == JHVB_RUN && comm_ready;
      clocks_run <= pst_r != JHVB_STOP;
      nmi_req <= pst_r == JHVB_STOP && bus_rise;
      irq <= irq_enable_bit_r && vcode != SRC_NONE;
    end
  end

  vec_align_a: assert property (@(posedge clk) disable iff (rst)
    rvalid && rd_isv_r |-> rdata[1:0] == 2'b00 && rdata[31:6] == 26'h0)
    else $error("vector not in steps of four");

  vec_prio_a: assert property (@(posedge clk) disable iff (rst)
    fl_r[SRC_WAKE] |-> vcode == SRC_WAKE)
    else $error("wakeup not shown first");

  vec_code_a: assert property (@(posedge clk) disable iff (rst)
    fl_r == 8'h06 |-> vcode == SRC_IFR + 4'h1)
    else $error("wrong source code");

  rd_clear_a: assert property (@(posedge clk) disable iff (rst)
    isv_rd_now && vcode == SRC_ARB && !arb_lost |=> !fl_r[SRC_ARB])
    else $error("vector read did not clear source");

  rx_keep_a: assert property (@(posedge clk) disable iff (rst)
    isv_rd_now && vcode == SRC_RXF |=> fl_r[SRC_RXF] && arm_rx_r)
    else $error("rx full cleared by vector read alone");

  eod_clear_a: assert property (@(posedge clk) disable iff (rst)
    eod_wr_now && !tx_first_bit |=> !fl_r[SRC_TXE])
    else $error("end of data did not clear tx empty");

  rx_copy_a: assert property (@(posedge clk) disable iff (rst)
    ce && rx_byte_valid && !rx_is_ifr |=>
      rx_shadow_r == $past(rx_byte) && fl_r[SRC_RXF])
    else $error("received byte not stored");

  underrun_a: assert property (@(posedge clk) disable iff (rst)
    ce && tx_need && !tx_full_r && !end_of_data_request |=> tx_abort)
    else $error("underrun not aborted");

  wait_quiet_a: assert property (@(posedge clk) disable iff (rst)
    pst_r == JHVB_WAIT && $past(pst_r) == JHVB_WAIT |-> !bus_drive_en)
    else $error("bus driven in wait");

  stop_nmi_a: assert property (@(posedge clk) disable iff (rst)
    ce && pst_r == JHVB_STOP && bus_rise |=> nmi_req && pst_r == JHVB_RUN)
    else $error("stop wake missing nmi");

endmodule

// ### verification/jhvb_link_model.sv
`timescale 1ns/1ps
module jhvb_link_model (
  input wire logic clk,
  input wire logic tx_load,
  input wire logic tx_abort,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_is_ifr,
  output logic rx_eof,
  output logic rx_busy,
  output logic arb_lost,
  output logic crc_err,
  output logic symbol_err,
  output logic tx_need,
  output logic tx_first_bit,
  output logic eod_done,
  output logic bus_rx
);
  initial begin
    {rx_byte_valid, rx_is_ifr, rx_eof, rx_busy, arb_lost} = '0;
    {crc_err, symbol_err, tx_need, tx_first_bit, eod_done} = '0;
    rx_byte = 8'h00;
    bus_rx = 1'b0;
  end
  // Byte lanes show the inverse once released, so stale data never matches
  task automatic rx(input logic [7:0] b, input logic in_frame_response);
    @(posedge clk);
    rx_byte <= b;
    rx_is_ifr <= in_frame_response;
    rx_byte_valid <= 1'b1;
    rx_busy <= 1'b1;
    @(posedge clk);
    rx_byte <= ~b;
    rx_is_ifr <= ~in_frame_response;
    rx_byte_valid <= 1'b0;
    rx_busy <= 1'b0;
  endtask
  // Bits: eof, arb, crc, sym, need, eod_done
  task automatic ev(input logic [5:0] m);
    @(posedge clk);
    {rx_eof, arb_lost, crc_err, symbol_err, tx_need, eod_done} <= m;
    @(posedge clk);
    {rx_eof, arb_lost, crc_err, symbol_err, tx_need, eod_done} <= '0;
  endtask
  // Passive-to-active edge; bus returns passive (low) after
  task automatic wake();
    @(posedge clk);
    bus_rx <= 1'b1;
    repeat (4) @(posedge clk);
    bus_rx <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (tx_load) begin
      repeat (3) @(posedge clk);
      tx_first_bit <= 1'b1;
      @(posedge clk);
      tx_first_bit <= 1'b0;
    end
  end
  // A halted frame is seen on the wire as a bad symbol
  always @(posedge clk) begin
    if (tx_abort) begin
      repeat (4) @(posedge clk);
      symbol_err <= 1'b1;
      @(posedge clk);
      symbol_err <= 1'b0;
    end
  end
endmodule

// ### verification/jhvb_top_bench.sv
`timescale 1ns/1ps
module jhvb_top_bench;
  import jhvb_pkg::*;
  localparam logic [7:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STA = {IDX_STAT, 2'b00};
  localparam logic [7:0] A_VEC = {IDX_ISV, 2'b00};
  localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [5:0] EV_EOF = 6'h20;
  localparam logic [5:0] EV_ERR = 6'h1c;
  localparam logic [5:0] EV_NEED = 6'h02;
  localparam logic [5:0] EV_EODD = 6'h01;
  logic clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_wait, cpu_stop;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic rx_byte_valid, rx_is_ifr, rx_eof, rx_busy, arb_lost, crc_err;
  logic symbol_err, tx_need, tx_first_bit, eod_done, bus_rx, tx_load;
  logic tx_abort, end_of_data_request, bus_drive_en, clocks_run;
  logic comm_ready, wake_byte_ok, irq, nmi_req;
  logic [7:0] rx_byte, tx_byte, last_tx;
  int n_mismatch = 0;
  int checks = 0;
  int n_abort = 0;
  int n_nmi = 0;
  int i;
  logic [7:0] prio [5] = '{8'h1c, 8'h18, 8'h14, 8'h04, 8'h00};
  jhvb_top dut (.clk, .rst, .ce, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .rx_byte_valid, .rx_byte,
    .rx_is_ifr, .rx_eof, .rx_busy, .arb_lost, .crc_err, .symbol_err,
    .tx_need, .tx_first_bit, .eod_done, .cpu_wait, .cpu_stop, .bus_rx,
    .tx_load, .tx_byte, .tx_abort, .end_of_data_request, .bus_drive_en,
    .clocks_run, .comm_ready, .wake_byte_ok, .irq, .nmi_req);
  jhvb_link_model lnk (.clk, .tx_load, .tx_abort, .rx_byte_valid,
    .rx_byte, .rx_is_ifr, .rx_eof, .rx_busy, .arb_lost, .crc_err,
    .symbol_err, .tx_need, .tx_first_bit, .eod_done, .bus_rx);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tx_load) last_tx <= tx_byte;
    if (tx_abort) n_abort <= n_abort + 1;
    if (nmi_req) n_nmi <= n_nmi + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // No limit here: a hung handshake is left to the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    wr(a, d);
    chk({30'h0, rs}, {30'h0, e});
  endtask
  task automatic cpu(input logic s);
    @(posedge clk);
    cpu_stop <= s;
    cpu_wait <= ~s;
    @(posedge clk);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rst, ce, awvalid, wvalid, bready, arvalid, rready} = 7'b1100000;
    {cpu_wait, cpu_stop} = 2'b00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(A_VEC, 32'h0);
    wc(A_VEC, 32'h20, RESP_OKAY);
    rc(A_VEC, 32'h0);
    wc(8'h00, 32'h1, RESP_SLVERR);
    rd(8'h00);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(v, 32'h0);
    lnk.ev(EV_EOF | EV_ERR);
    for (i = 0; i < 5; i++) rc(A_VEC, prio[i]);
    // Second byte lands before the host reads the first
    lnk.rx(8'ha5, 1'b0);
    lnk.rx(8'h3c, 1'b0);
    rc(A_VEC, 32'h0c);
    rc(A_VEC, 32'h0c);
    rc(A_DAT, 32'h3c);
    rc(A_VEC, 32'h0);
    lnk.rx(8'hc3, 1'b1);
    rc(A_DAT, 32'hc3);
    rc(A_VEC, 32'h08);
    rc(A_DAT, 32'hc3);
    rc(A_VEC, 32'h0);
    // Response byte and plain byte pending together
    lnk.rx(8'h11, 1'b1);
    lnk.rx(8'h22, 1'b0);
    rc(A_VEC, 32'h0c);
    rc(A_DAT, 32'h22);
    rc(A_VEC, 32'h08);
    rc(A_DAT, 32'h22);
    rc(A_VEC, 32'h0);
    wc(A_DAT, 32'h5a, RESP_OKAY);
    lnk.ev(EV_NEED);
    repeat (8) @(posedge clk);
    chk(last_tx, 8'h5a);
    rc(A_VEC, 32'h10);
    wc(A_DAT, 32'h96, RESP_OKAY);
    rc(A_VEC, 32'h0);
    lnk.ev(EV_NEED);
    repeat (8) @(posedge clk);
    chk(last_tx, 8'h96);
    rc(A_VEC, 32'h10);
    wc(A_CTL, 32'h4, RESP_OKAY);
    @(negedge clk);
    chk1(end_of_data_request, 1'b1);
    rc(A_VEC, 32'h0);
    lnk.ev(EV_EODD);
    @(negedge clk);
    chk1(end_of_data_request, 1'b0);
    lnk.ev(EV_NEED);
    repeat (8) @(posedge clk);
    chk(n_abort, 1);
    rc(A_VEC, 32'h1c);
    rc(A_VEC, 32'h0);
    wc(A_CTL, 32'h2, RESP_OKAY);
    cpu(1'b0);
    repeat (2) @(posedge clk);
    rd(A_STA);
    chk(v & 32'h3, 32'h1);
    chk1(bus_drive_en, 1'b0);
    lnk.ev(EV_EOF);
    repeat (2) @(posedge clk);
    rd(A_STA);
    chk(v & 32'h3, 32'h0);
    chk1(irq, 1'b1);
    rc(A_VEC, 32'h04);
    @(negedge clk);
    chk1(irq, 1'b0);
    cpu(1'b1);
    repeat (2) @(posedge clk);
    chk1(clocks_run, 1'b0);
    chk1(wake_byte_ok, 1'b0);
    rd(A_STA);
    chk(v & 32'h3, 32'h2);
    lnk.wake();
    repeat (6) @(posedge clk);
    chk(n_nmi, 1);
    chk1(clocks_run, 1'b1);
    chk1(comm_ready, 1'b0);
    rc(A_VEC, 32'h20);
    repeat (RESTAB_CYC) @(posedge clk);
    chk1(comm_ready, 1'b1);
    chk1(bus_drive_en, 1'b1);
    wc(A_CTL, 32'h3, RESP_OKAY);
    cpu(1'b0);
    repeat (2) @(posedge clk);
    rd(A_STA);
    chk(v & 32'h7, 32'h6);
    chk1(wake_byte_ok, 1'b1);
    lnk.wake();
    repeat (6) @(posedge clk);
    chk(n_nmi, 2);
    wrap_up();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
